//--- rtl/gpio_pint_defs.svh
`ifndef GPIO_PINT_DEFS_SVH
`define GPIO_PINT_DEFS_SVH

// Sizes
`define PIN_CNT        32
`define CHAN_CNT       6
`define PERIPH_CNT     4
`define ADDR_W         12

// Port register byte offsets
`define GP_FUNC        12'h000
`define GP_FUNC_SET    12'h004
`define GP_FUNC_CLR    12'h008
`define GP_DATA        12'h00C
`define GP_DATA_SET    12'h010
`define GP_DATA_CLR    12'h014
`define GP_DATA_TGL    12'h018
`define GP_DIR         12'h01C
`define GP_DIR_SET     12'h020
`define GP_DIR_CLR     12'h024
`define GP_INEN        12'h028
`define GP_MUX_LO      12'h02C
`define GP_MUX_HI      12'h030
`define GP_IMASK       12'h034
`define GP_ISENS       12'h038
`define GP_IBOTH       12'h03C
`define GP_ILATCH      12'h040
`define GP_PINS        12'h044

// Bank select in paddr[11:9] and channel offsets in paddr[5:0]
`define GP_BANK        3'h0
`define PC_BANK        3'h1
`define PC_MSK_SET     6'h00
`define PC_MSK_CLR     6'h04
`define PC_REQ         6'h08
`define PC_ASSIGN      6'h0C
`define PC_EDGE_SET    6'h10
`define PC_EDGE_CLR    6'h14
`define PC_INV_SET     6'h18
`define PC_INV_CLR     6'h1C
`define PC_PINSTATE    6'h20
`define PC_LATCH       6'h24

// Assign field: per byte lane, bit 7 enable, bits 1:0 half port
`define LANE_EN_BIT    7

// Reset values
`define REG_RST        32'h00000000
`define INEN_RST       32'hFFFFFFFF

`endif

//--- rtl/gpio_pint_pkg.sv
package gpio_pint_pkg;

  typedef logic [31:0] word_t;

  // One pin interrupt channel's state
  typedef struct packed {
    word_t mask;
    word_t edgeSel;
    word_t invPol;
    word_t latch;
    word_t assignSel;
    word_t prev;
  } pint_chan_t;

  // Peripheral side data or enables, one word per function
  typedef logic [3:0][31:0] periph_bus_t;

endpackage : gpio_pint_pkg

//--- rtl/gpio_pin_interrupt_mux.sv
// Behaviour
// - Pins interrupt by edge or level, polarity selectable
// - Pin channels independent of GPIO data logic
// - Six channels, each up to 32 inputs
// - Half-port groups of eight mapped per channel
// - Per-channel 32-bit assign, mask, request, clear registers
// - Pin states and latches readable regardless of mask
// - Set and clear addresses modify only one-bits
// - Per-pin direction bit selects input or output
// - Data set/clear/toggle change only one-bits
// - Per-pin mask; outputs interrupt on driven data
// - Level or edge; rising or both edges
// - Per-pin choice of GPIO or four peripherals
// - Output plus input enable loops data back
//
// The APB slave port and the register addresses were left to the implementer.
`timescale 1ns/100ps
`include "gpio_pint_defs.svh"

module gpio_pin_interrupt_mux (
  input  wire logic                       clock,
  input  wire logic                       srst,
  input  wire logic                       psel,
  input  wire logic                       penable,
  input  wire logic                       pwrite,
  input  wire logic [`ADDR_W-1:0]         paddr,
  input  wire logic [31:0]                pwdata,
  output logic      [31:0]                prdata_ff,
  output logic                            pready_ff,
  output logic                            pslverr_ff,
  input  wire logic [`PIN_CNT-1:0]        pinIn,
  output logic      [`PIN_CNT-1:0]        pinOut_ff,
  output logic      [`PIN_CNT-1:0]        pinOeN_ff,
  input  wire gpio_pint_pkg::periph_bus_t perDout,
  input  wire gpio_pint_pkg::periph_bus_t perDoe,
  output logic      [`PIN_CNT-1:0]        perDin_ff,
  output logic      [`CHAN_CNT-1:0]       pinIrq_ff,
  output logic                            gpioIrq_ff
);

  logic [31:0] pinMeta_ff;
  logic [31:0] pinSync_ff;
  logic [31:0] rxVal;
  logic [31:0] outInt;
  logic [31:0] oeInt;
  logic [63:0] muxAll;
  logic        setupDone;
  logic        wrEn;
  logic        gpioHit;
  logic        chanHit;
  logic [2:0]  chSel;
  logic [31:0] rdData;
  logic        rdErr;
  logic [31:0] nxt_prdata;
  logic        nxt_pready;
  logic        nxt_pslverr;

  logic [31:0] func_ff, data_ff, dir_ff, inen_ff, muxLo_ff, muxHi_ff;
  logic [31:0] imask_ff, isens_ff, iboth_ff, ilatch_ff, gprev_ff;
  logic [31:0] nxt_func, nxt_data, nxt_dir, nxt_inen, nxt_muxLo, nxt_muxHi;
  logic [31:0] nxt_imask, nxt_isens, nxt_iboth, nxt_ilatch, nxt_gprev;
  logic [31:0] gsrc;
  logic [31:0] gEvt;
  logic        nxt_gpioIrq;

  gpio_pint_pkg::pint_chan_t chan_ff  [`CHAN_CNT];
  gpio_pint_pkg::pint_chan_t nxt_chan [`CHAN_CNT];
  logic [31:0]               laneIn   [`CHAN_CNT];

  // Two-stage synchroniser on the pads
  always_ff @(posedge clock) begin
    if (srst) begin
      pinMeta_ff <= `REG_RST;
      pinSync_ff <= `REG_RST;
    end else begin
      pinMeta_ff <= pinIn;
      pinSync_ff <= pinMeta_ff;
    end
  end

  // APB: one wait state, writes land on the completing edge
  assign setupDone = psel & penable & ~pready_ff;
  assign wrEn      = psel & penable & pready_ff & pwrite;
  assign gpioHit   = (paddr[11:9] == `GP_BANK);
  assign chanHit   = (paddr[11:9] == `PC_BANK) && (paddr[8:6] < 3'h6);
  assign chSel     = chanHit ? paddr[8:6] : 3'h0;

  // Read mux; reads have no side effects
  always_comb begin
    rdData = 32'h00000000;
    rdErr  = 1'b0;
    if (gpioHit) begin
      case (paddr)
        `GP_FUNC, `GP_FUNC_SET, `GP_FUNC_CLR: rdData = func_ff;
        `GP_DATA, `GP_DATA_SET, `GP_DATA_CLR, `GP_DATA_TGL: rdData = data_ff;
        `GP_DIR, `GP_DIR_SET, `GP_DIR_CLR: rdData = dir_ff;
        `GP_INEN:   rdData = inen_ff;
        `GP_MUX_LO: rdData = muxLo_ff;
        `GP_MUX_HI: rdData = muxHi_ff;
        `GP_IMASK:  rdData = imask_ff;
        `GP_ISENS:  rdData = isens_ff;
        `GP_IBOTH:  rdData = iboth_ff;
        `GP_ILATCH: rdData = ilatch_ff;
        `GP_PINS:   rdData = rxVal;
        default:    rdErr  = 1'b1;
      endcase
    end else if (chanHit) begin
      case (paddr[5:0])
        `PC_MSK_SET, `PC_MSK_CLR:   rdData = chan_ff[chSel].mask;
        `PC_REQ:      rdData = chan_ff[chSel].latch & chan_ff[chSel].mask;
        `PC_ASSIGN:   rdData = chan_ff[chSel].assignSel;
        `PC_EDGE_SET, `PC_EDGE_CLR: rdData = chan_ff[chSel].edgeSel;
        `PC_INV_SET, `PC_INV_CLR:   rdData = chan_ff[chSel].invPol;
        `PC_PINSTATE: rdData = laneIn[chSel];
        `PC_LATCH:    rdData = chan_ff[chSel].latch;
        default:      rdErr  = 1'b1;
      endcase
    end else begin
      rdErr = 1'b1;
    end
  end

  // Bus answer next values
  always_comb begin
    nxt_pready  = setupDone;
    nxt_prdata  = setupDone ? rdData : prdata_ff;
    nxt_pslverr = setupDone & rdErr;
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      pready_ff  <= 1'b0;
      prdata_ff  <= `REG_RST;
      pslverr_ff <= 1'b0;
    end else begin
      pready_ff  <= nxt_pready;
      prdata_ff  <= nxt_prdata;
      pslverr_ff <= nxt_pslverr;
    end
  end

  // Pad and peripheral selection per pin
  assign muxAll = {muxHi_ff, muxLo_ff};
  genvar gi;
  generate
    for (gi = 0; gi < `PIN_CNT; gi++) begin : g_pin
      logic [1:0] sel;
      assign sel = muxAll[2*gi +: 2];
      assign outInt[gi] = func_ff[gi] ? perDout[sel][gi] : data_ff[gi];
      assign oeInt[gi]  = func_ff[gi] ? perDoe[sel][gi]  : dir_ff[gi];
      // Driven pins with input enabled see their own output data
      assign rxVal[gi]  = ~inen_ff[gi] ? 1'b0 :
                          (~pinOeN_ff[gi] ? pinOut_ff[gi] : pinSync_ff[gi]);
      // Output pins raise events only from what software drives
      assign gsrc[gi]   = dir_ff[gi] ? data_ff[gi] : rxVal[gi];
    end
  endgenerate

  // Port event detect: level, rising, or both edges
  assign gEvt = (isens_ff & iboth_ff & (gsrc ^ gprev_ff))
              | (isens_ff & ~iboth_ff & gsrc & ~gprev_ff)
              | (~isens_ff & gsrc);

  // Port register writes
  always_comb begin
    nxt_func   = func_ff;
    nxt_data   = data_ff;
    nxt_dir    = dir_ff;
    nxt_inen   = inen_ff;
    nxt_muxLo  = muxLo_ff;
    nxt_muxHi  = muxHi_ff;
    nxt_imask  = imask_ff;
    nxt_isens  = isens_ff;
    nxt_iboth  = iboth_ff;
    nxt_ilatch = ilatch_ff;
    nxt_gprev  = gsrc;
    if (wrEn && gpioHit) begin
      case (paddr)
        `GP_FUNC:     nxt_func   = pwdata;
        `GP_FUNC_SET: nxt_func   = func_ff | pwdata;
        `GP_FUNC_CLR: nxt_func   = func_ff & ~pwdata;
        `GP_DATA:     nxt_data   = pwdata;
        `GP_DATA_SET: nxt_data   = data_ff | pwdata;
        `GP_DATA_CLR: nxt_data   = data_ff & ~pwdata;
        `GP_DATA_TGL: nxt_data   = data_ff ^ pwdata;
        `GP_DIR:      nxt_dir    = pwdata;
        `GP_DIR_SET:  nxt_dir    = dir_ff | pwdata;
        `GP_DIR_CLR:  nxt_dir    = dir_ff & ~pwdata;
        `GP_INEN:     nxt_inen   = pwdata;
        `GP_MUX_LO:   nxt_muxLo  = pwdata;
        `GP_MUX_HI:   nxt_muxHi  = pwdata;
        `GP_IMASK:    nxt_imask  = pwdata;
        `GP_ISENS:    nxt_isens  = pwdata;
        `GP_IBOTH:    nxt_iboth  = pwdata;
        `GP_ILATCH:   nxt_ilatch = ilatch_ff & ~pwdata;
        default:      nxt_func   = func_ff;
      endcase
    end
    nxt_ilatch  = nxt_ilatch | gEvt; // Set beats clear
    nxt_gpioIrq = |(ilatch_ff & imask_ff);
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      func_ff    <= `REG_RST;
      data_ff    <= `REG_RST;
      dir_ff     <= `REG_RST;
      inen_ff    <= `INEN_RST;
      muxLo_ff   <= `REG_RST;
      muxHi_ff   <= `REG_RST;
      imask_ff   <= `REG_RST;
      isens_ff   <= `REG_RST;
      iboth_ff   <= `REG_RST;
      ilatch_ff  <= `REG_RST;
      gprev_ff   <= `REG_RST;
      gpioIrq_ff <= 1'b0;
      pinOut_ff  <= `REG_RST;
      pinOeN_ff  <= `INEN_RST;
      perDin_ff  <= `REG_RST;
    end else begin
      func_ff    <= nxt_func;
      data_ff    <= nxt_data;
      dir_ff     <= nxt_dir;
      inen_ff    <= nxt_inen;
      muxLo_ff   <= nxt_muxLo;
      muxHi_ff   <= nxt_muxHi;
      imask_ff   <= nxt_imask;
      isens_ff   <= nxt_isens;
      iboth_ff   <= nxt_iboth;
      ilatch_ff  <= nxt_ilatch;
      gprev_ff   <= nxt_gprev;
      gpioIrq_ff <= nxt_gpioIrq;
      pinOut_ff  <= outInt;
      pinOeN_ff  <= ~oeInt;
      perDin_ff  <= rxVal;
    end
  end

  // Pin interrupt channels, fed from the receive path only
  genvar gc, gl;
  generate
    for (gc = 0; gc < `CHAN_CNT; gc++) begin : g_chan
      logic [31:0] pol;
      logic [31:0] evt;
      logic        chWr;
      for (gl = 0; gl < 4; gl++) begin : g_lane
        logic [1:0] hp;
        assign hp = chan_ff[gc].assignSel[8*gl +: 2];
        assign laneIn[gc][8*gl +: 8] = chan_ff[gc].assignSel[8*gl + `LANE_EN_BIT] ?
                                       rxVal[{hp, 3'h0} +: 8] : 8'h00;
      end
      assign pol  = laneIn[gc] ^ chan_ff[gc].invPol;
      assign evt  = (chan_ff[gc].edgeSel & pol & ~chan_ff[gc].prev)
                  | (~chan_ff[gc].edgeSel & pol);
      assign chWr = wrEn && chanHit && (paddr[8:6] == 3'(gc));

      always_comb begin
        nxt_chan[gc]      = chan_ff[gc];
        nxt_chan[gc].prev = pol;
        if (chWr) begin
          case (paddr[5:0])
            `PC_MSK_SET:  nxt_chan[gc].mask      = chan_ff[gc].mask | pwdata;
            `PC_MSK_CLR:  nxt_chan[gc].mask      = chan_ff[gc].mask & ~pwdata;
            `PC_ASSIGN:   nxt_chan[gc].assignSel = pwdata;
            `PC_EDGE_SET: nxt_chan[gc].edgeSel   = chan_ff[gc].edgeSel | pwdata;
            `PC_EDGE_CLR: nxt_chan[gc].edgeSel   = chan_ff[gc].edgeSel & ~pwdata;
            `PC_INV_SET:  nxt_chan[gc].invPol    = chan_ff[gc].invPol | pwdata;
            `PC_INV_CLR:  nxt_chan[gc].invPol    = chan_ff[gc].invPol & ~pwdata;
            `PC_REQ, `PC_LATCH: nxt_chan[gc].latch = chan_ff[gc].latch & ~pwdata;
            default:      nxt_chan[gc].prev      = pol;
          endcase
        end
        // Latch fills regardless of mask; new events beat a clear
        nxt_chan[gc].latch = nxt_chan[gc].latch | evt;
      end

      always_ff @(posedge clock) begin
        if (srst) begin
          chan_ff[gc]   <= '0;
          pinIrq_ff[gc] <= 1'b0;
        end else begin
          chan_ff[gc]   <= nxt_chan[gc];
          pinIrq_ff[gc] <= |(chan_ff[gc].latch & chan_ff[gc].mask);
        end
      end
    end
  endgenerate

  // Channel 0 polarity and channel 1 request, watched by the checks below
  logic [31:0] pol0;
  logic        ch1Req;
  assign pol0   = laneIn[0] ^ chan_ff[0].invPol;
  assign ch1Req = |(chan_ff[1].latch & chan_ff[1].mask);

  default clocking cb @(posedge clock); endclocking
  default disable iff (srst);

  sequence s_wr(logic [11:0] a);
    wrEn && paddr == a;
  endsequence

  property p_dataSet;
    s_wr(`GP_DATA_SET) |=> (data_ff == ($past(data_ff) | $past(pwdata)));
  endproperty
  a_dataSet: assert property (p_dataSet) else $error("data set altered other pins");

  property p_dataTgl;
    s_wr(`GP_DATA_TGL) |=> (data_ff == ($past(data_ff) ^ $past(pwdata)));
  endproperty
  a_dataTgl: assert property (p_dataTgl) else $error("data toggle wrong");

  property p_maskClr;
    s_wr({`PC_BANK, 3'h0, `PC_MSK_CLR})
      |=> chan_ff[0].mask == ($past(chan_ff[0].mask) & ~$past(pwdata));
  endproperty
  a_maskClr: assert property (p_maskClr) else $error("mask clear wrong");

  property p_dirDrive;
    (!func_ff[0] && dir_ff[0]) |=> !pinOeN_ff[0];
  endproperty
  a_dirDrive: assert property (p_dirDrive) else $error("output pin not driven");

  property p_loop;
    (inen_ff[0] && !pinOeN_ff[0]) |=> perDin_ff[0] == $past(pinOut_ff[0]);
  endproperty
  a_loop: assert property (p_loop) else $error("loopback path broken");

  property p_levelLatch;
    (!chan_ff[0].edgeSel[0] && pol0[0])
      |=> chan_ff[0].latch[0] ##1 (pinIrq_ff[0] || !$past(chan_ff[0].mask[0]));
  endproperty
  a_levelLatch: assert property (p_levelLatch) else $error("level not latched");

  property p_edgeLatch;
    (chan_ff[0].edgeSel[0] && pol0[0] && !chan_ff[0].prev[0] && (chan_ff[0].mask == '0))
      |=> chan_ff[0].latch[0] && !pinIrq_ff[0];
  endproperty
  a_edgeLatch: assert property (p_edgeLatch) else $error("masked edge lost");

  property p_irq;
    ##1 pinIrq_ff[1] == $past(ch1Req);
  endproperty
  a_irq: assert property (p_irq) else $error("channel request mismatch");

  property p_gpioIrq;
    (|(ilatch_ff & imask_ff)) |=> gpioIrq_ff;
  endproperty
  a_gpioIrq: assert property (p_gpioIrq) else $error("port irq missing");

  property p_ready;
    setupDone |=> pready_ff ##1 !pready_ff;
  endproperty
  a_ready: assert property (p_ready) else $error("bus answer timing wrong");

endmodule : gpio_pin_interrupt_mux

//--- verification/pin_board.sv
`timescale 1ns/100ps

// Board side of the port pins
module pin_board (
  input  wire logic [31:0] pinOut,
  input  wire logic [31:0] pinOeN,
  input  wire logic [31:0] extLvl,
  output logic      [31:0] pinIn
);
  // Pad level: the port's own drive wins, else the board's level
  always_comb begin
    for (int i = 0; i < 32; i++) begin
      pinIn[i] = pinOeN[i] ? extLvl[i] : pinOut[i];
    end
  end
endmodule : pin_board

//--- verification/tb_top.sv
`timescale 1ns/100ps
`include "gpio_pint_defs.svh"

module tb_top;
  logic                       clock;
  logic                       srst;
  logic                       psel;
  logic                       penable;
  logic                       pwrite;
  logic [11:0]                paddr;
  logic [31:0]                pwdata;
  logic [31:0]                prdata;
  logic                       pready;
  logic                       pslverr;
  logic [31:0]                pinIn;
  logic [31:0]                pinOut;
  logic [31:0]                pinOeN;
  logic [31:0]                perDin;
  logic [31:0]                extLvl;
  logic [31:0]                rd;
  logic [31:0]                m;
  logic                       slvErr;
  logic [5:0]                 pinIrq;
  logic                       gpioIrq;
  gpio_pint_pkg::periph_bus_t perDout;
  gpio_pint_pkg::periph_bus_t perDoe;
  int                         mismatches;
  int                         numChecks;
  int                         h;
  int                         p;

  gpio_pin_interrupt_mux dut_u (
    .clock(clock), .srst(srst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata_ff(prdata), .pready_ff(pready),
    .pslverr_ff(pslverr), .pinIn(pinIn), .pinOut_ff(pinOut), .pinOeN_ff(pinOeN),
    .perDout(perDout), .perDoe(perDoe), .perDin_ff(perDin), .pinIrq_ff(pinIrq),
    .gpioIrq_ff(gpioIrq)
  );

  pin_board board_u (.pinOut(pinOut), .pinOeN(pinOeN), .extLvl(extLvl), .pinIn(pinIn));

  // Clock at 50 ns period
  initial begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end

  // One APB transfer; holds the request until pready is seen high
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
    @(posedge clock);
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= d;
    @(posedge clock);
    penable <= 1'b1;
    do begin
      @(posedge clock);
    end while (pready !== 1'b1);
    rd      = prdata;
    slvErr  = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    numChecks++;
    if (seen !== exp) begin
      mismatches++;
      $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic rdChk(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h00000000);
    check(rd, exp);
  endtask : rdChk

  // Let pin synchronisers, latches and outputs settle
  task automatic settle();
    repeat (8) @(posedge clock);
  endtask : settle

  function automatic logic [11:0] ca(input int c, input logic [5:0] o);
    return 12'h200 + 12'(c * 64) + {6'h00, o};
  endfunction : ca

  task automatic give_verdict();
    $display("Checks %0d, mismatches %0d", numChecks, mismatches);
    if (mismatches == 0 && numChecks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask : give_verdict

  // Watchdog against a hung handshake
  initial begin
    repeat (40000) @(posedge clock);
    mismatches++;
    give_verdict();
  end

  // Main sequence
  initial begin
    srst = 1'b1;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h00000000;
    extLvl = 32'h00000000;
    perDout = '0;
    perDoe = '0;
    mismatches = 0;
    numChecks = 0;
    repeat (5) @(posedge clock);
    srst <= 1'b0;
    // Reset values
    rdChk(`GP_INEN, 32'hFFFFFFFF);
    rdChk(`GP_DIR, 32'h00000000);
    check(pinOeN, 32'hFFFFFFFF);
    // Channel c takes half port c mod 4 into lane c mod 4; channels 4 and 5 reuse those of 0 and 1
    for (int c = 0; c < 6; c++) begin
      h = c % 4;
      p = 8 * h + c;
      m = 32'h00000001 << (8 * h + c);
      apb(1'b1, ca(c, `PC_ASSIGN), (32'h00000080 | 32'(h)) << (8 * h));
      apb(1'b1, ca(c, `PC_MSK_SET), m);
      apb(1'b1, ca(c, `PC_EDGE_SET), m);
      rdChk(ca(c, `PC_MSK_CLR), m);
      extLvl[p] <= 1'b1;
      settle();
      check(32'(pinIrq[c]), 32'h00000001);
      apb(1'b0, ca(c, `PC_PINSTATE), 32'h00000000);
      check(rd & m, m);
      rdChk(ca(c, `PC_REQ), m);
      apb(1'b1, ca(c, `PC_LATCH), m);
      settle();
      check(32'(pinIrq[c]), 32'h00000000);
      rdChk(ca(c, `PC_LATCH), 32'h00000000);
      // Masked rising edge: latch fills, no request
      apb(1'b1, ca(c, `PC_MSK_CLR), m);
      extLvl[p] <= 1'b0;
      settle();
      extLvl[p] <= 1'b1;
      settle();
      check(32'(pinIrq[c]), 32'h00000000);
      rdChk(ca(c, `PC_LATCH), m);
      apb(1'b1, ca(c, `PC_LATCH), m);
      // Masked, active-low level: latch still fills, no request
      extLvl[p] <= 1'b0;
      apb(1'b1, ca(c, `PC_EDGE_CLR), m);
      apb(1'b1, ca(c, `PC_INV_SET), m);
      settle();
      check(32'(pinIrq[c]), 32'h00000000);
      rdChk(ca(c, `PC_LATCH), m);
      rdChk(ca(c, `PC_REQ), 32'h00000000);
      apb(1'b1, ca(c, `PC_LATCH), m);
      rdChk(ca(c, `PC_LATCH), m);
      apb(1'b1, ca(c, `PC_ASSIGN), 32'h00000000);
      apb(1'b1, ca(c, `PC_INV_CLR), m);
      check(pinOeN, 32'hFFFFFFFF);
    end
    apb(1'b0, ca(6, `PC_REQ), 32'h00000000);
    check(32'(slvErr), 32'h00000001);
    // Port latch saw every channel pin in level mode; clear it all
    rdChk(`GP_ILATCH, 32'h08042211);
    apb(1'b1, `GP_ILATCH, 32'hFFFFFFFF);
    // Port interrupt on pin 8, both edges then rising only
    apb(1'b1, `GP_IMASK, 32'h00000100);
    apb(1'b1, `GP_ISENS, 32'h00000100);
    apb(1'b1, `GP_IBOTH, 32'h00000100);
    extLvl[8] <= 1'b1;
    settle();
    check(32'(gpioIrq), 32'h00000001);
    rdChk(`GP_ILATCH, 32'h00000100);
    apb(1'b1, `GP_ILATCH, 32'h00000100);
    settle();
    check(32'(gpioIrq), 32'h00000000);
    extLvl[8] <= 1'b0;
    settle();
    check(32'(gpioIrq), 32'h00000001);
    apb(1'b1, `GP_IBOTH, 32'h80000000);
    apb(1'b1, `GP_ILATCH, 32'h00000100);
    extLvl[8] <= 1'b1;
    settle();
    apb(1'b1, `GP_ILATCH, 32'h00000100);
    extLvl[8] <= 1'b0;
    settle();
    check(32'(gpioIrq), 32'h00000000);
    // Output pin 9 interrupts from the data software drives
    apb(1'b1, `GP_IMASK, 32'h00000200);
    apb(1'b1, `GP_DIR_SET, 32'h00000200);
    check(32'(gpioIrq), 32'h00000000);
    apb(1'b1, `GP_DATA_SET, 32'h00000200);
    settle();
    check(32'(gpioIrq), 32'h00000001);
    // Direction and write-one-to-modify data
    apb(1'b1, `GP_DIR_SET, 32'h0000000F);
    apb(1'b1, `GP_DATA_SET, 32'h00000005);
    settle();
    check(pinOut & 32'h0000000F, 32'h00000005);
    check(pinOeN & 32'h0000000F, 32'h00000000);
    apb(1'b1, `GP_DATA_CLR, 32'h00000001);
    apb(1'b1, `GP_DATA_TGL, 32'h00000003);
    rdChk(`GP_DATA, 32'h00000207);
    apb(1'b1, `GP_DIR_CLR, 32'h00000008);
    rdChk(`GP_DIR, 32'h00000207);
    settle();
    check(pinOut & 32'h00000007, 32'h00000007);
    check(pinOeN & 32'h0000000F, 32'h00000008);
    // Loopback of driven pins into the receive path
    apb(1'b0, `GP_PINS, 32'h00000000);
    check(rd & 32'h0000000F, 32'h00000007);
    check(perDin & 32'h0000000F, 32'h00000007);
    apb(1'b1, `GP_INEN, 32'h00000000);
    settle();
    rdChk(`GP_PINS, 32'h00000000);
    apb(1'b1, `GP_INEN, 32'hFFFFFFFF);
    // Each of the four peripheral functions on pin 4
    apb(1'b1, `GP_FUNC_SET, 32'h00000010);
    for (int s = 0; s < 4; s++) begin
      apb(1'b1, `GP_MUX_LO, 32'(s) << 8);
      for (int k = 0; k < 4; k++) begin
        perDout[k] <= (k == s) ? 32'h00000010 : 32'h00000000;
        perDoe[k] <= (k == s) ? 32'h00000010 : 32'h00000000;
      end
      settle();
      check(32'(pinOut[4]), 32'h00000001);
      check(32'(pinOeN[4]), 32'h00000000);
    end
    apb(1'b1, `GP_FUNC_CLR, 32'h00000010);
    rdChk(`GP_FUNC, 32'h00000000);
    settle();
    check(32'(pinOeN[4]), 32'h00000001);
    give_verdict();
  end
endmodule : tb_top
